// >>> logic/rcu_top.sv
/*
  rcu_top: reset merging and stretching, oscillator control, stable flags and their
  interrupts, system clock selection and the derived clock ticks.
  Assumes a plain register port with read data one cycle after the read strobe, and
  that all inputs are synchronous to CLK.
*/
`timescale 1ns/1ps
module rcu_top
  import rcu_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [31:0] RDATA,
  input wire rcu_rst_src_t RST_SRC,
  input wire rcu_osc_t OSC_TICK,
  input wire rcu_rdy_t OSC_RDY,
  output rcu_oscen_t OSC_EN,
  output rcu_clk_t CLK_TICK,
  output logic POWER_RESET_N,
  output logic SYSTEM_RESET_N,
  output logic BACKUP_RESET_N,
  output logic [31:0] RESET_VECTOR,
  output logic STABLE_IRQ,
  output logic NMI
);
  typedef struct packed {
    logic pwr_n;
    logic sys_n;
    logic bkp_n;
    logic [8:0] stretch;
    logic internal_8m_osc_en;
    logic internal_40k_osc_en;
    logic hx_en;
    logic hx_bps;
    logic ckm_en;
    logic [2:0] pll_en;
    logic [4:0] stb;
    logic internal_40k_osc_stb;
    rcu_src_t system_clock_switch;
    rcu_src_t sel;
    logic [2:0] ahb_psc;
    logic [2:0] apb1_psc;
    logic [2:0] apb2_psc;
    logic [2:0] adc_psc;
    logic pll_src;
    logic [1:0] usb_psc;
    logic [1:0] i2s_sel;
    logic [4:0] flag;
    logic [4:0] ie;
    logic ckm_flag;
    rcu_rtc_t rtc_src;
    logic rtc_en;
    logic bkp_bit;
    logic [6:0] ahb_cnt;
    logic [6:0] apb1_cnt;
    logic [6:0] apb2_cnt;
    logic [2:0] tick_cnt;
    logic [3:0] adc_cnt;
    logic [1:0] usb_cnt;
    logic [6:0] rtc_cnt;
    logic [31:0] rdata;
    rcu_clk_t clk_o;
  } rcu_state_t;

  rcu_state_t st_reg;
  rcu_state_t st_next;

  logic pwr_src;
  logic sys_src;
  logic internal_8m_osc_on;
  logic hx_tick;
  logic hx_fail;
  logic sys_t;
  logic ahb_t;
  logic apb1_t;
  logic apb2_t;
  logic pll_t;
  logic [6:0] ahb_mask;
  logic [6:0] apb1_mask;
  logic [6:0] apb2_mask;
  logic [3:0] adc_top;
  logic [4:0] stb_set;
  logic [4:0] flag_clr;
  logic ckm_clr;

  // converter divide factors 2,4,6,8,12,16 as terminal counts
  function automatic logic [3:0] adc_top_of(input logic [2:0] psc);
    logic [3:0] top;
    top = 4'hF;
    case (psc)
      3'h0: top = 4'h1;
      3'h1: top = 4'h3;
      3'h2: top = 4'h5;
      3'h3: top = 4'h7;
      3'h4: top = 4'hB;
      default: top = 4'hF;
    endcase
    return top;
  endfunction : adc_top_of

  // one register update per edge; all hardware forcing is applied after software
  always_comb
  begin
    st_next = st_reg;
    flag_clr = 5'h00;
    ckm_clr = 1'b0;

    // reset merging and stretching
    pwr_src = RST_SRC.por_det | RST_SRC.standby_exit;
    pwr_src = pwr_src | !RST_SRC.ldo_ready;
    sys_src = pwr_src | !st_reg.pwr_n | !RST_SRC.external_reset_pin_n
      | !RST_SRC.window_watchdog_reset_n | !RST_SRC.free_watchdog_reset_n
      | RST_SRC.software_reset_request
      | (RST_SRC.standby_entry & !RST_SRC.standby_no_reset_option)
      | (RST_SRC.deepsleep_entry & !RST_SRC.deepsleep_no_reset_option);
    st_next.pwr_n = !pwr_src;
    if (sys_src)
    begin
      st_next.stretch = RCU_STRETCH_CYC;
    end
    else if (st_reg.stretch != 9'h000)
    begin
      st_next.stretch = st_reg.stretch - 9'h001;
    end
    // released from a flop, so the edge is synchronous to CLK
    st_next.sys_n = !sys_src && (st_reg.stretch == 9'h000);
    st_next.bkp_n = !(st_reg.bkp_bit | RST_SRC.bkp_power_on);

    // stable flags follow the ready levels only while enabled
    internal_8m_osc_on = st_reg.internal_8m_osc_en | st_reg.ckm_en | (st_reg.sel == RCU_SRC_INTERNAL_8M_OSC);
    st_next.stb[0] = internal_8m_osc_on & OSC_RDY.internal_8m_osc;
    st_next.stb[1] = st_reg.hx_en & OSC_RDY.high_speed_crystal;
    st_next.stb[2] = st_reg.pll_en[0] & OSC_RDY.pll;
    st_next.stb[3] = st_reg.pll_en[1] & OSC_RDY.pll1;
    st_next.stb[4] = st_reg.pll_en[2] & OSC_RDY.pll2;
    st_next.internal_40k_osc_stb = (st_reg.internal_40k_osc_en | RST_SRC.fwdg_started) & OSC_RDY.internal_40k_osc;
    stb_set = st_next.stb & ~st_reg.stb;

    // software writes
    if (WE)
    begin
      unique case (ADDR)
        RCU_CTL_OFS:
        begin
          st_next.internal_8m_osc_en = WDATA[CTL_INTERNAL_8M_OSC_EN];
          st_next.internal_40k_osc_en = WDATA[CTL_INTERNAL_40K_OSC_EN];
          st_next.hx_en = WDATA[CTL_HX_EN];
          st_next.ckm_en = WDATA[CTL_CKM_EN];
          st_next.pll_en = {WDATA[CTL_PLL_EN + 4], WDATA[CTL_PLL_EN + 2], WDATA[CTL_PLL_EN]};
          if (!st_reg.hx_en)
          begin
            st_next.hx_bps = WDATA[CTL_HX_BPS];
          end
        end
        RCU_CFG_OFS:
        begin
          if (WDATA[CFG_SCS +: 2] != 2'h3)
          begin
            st_next.system_clock_switch = rcu_src_t'(WDATA[CFG_SCS +: 2]);
          end
          st_next.ahb_psc = WDATA[CFG_AHB +: 3];
          st_next.apb1_psc = WDATA[CFG_APB1 +: 3];
          st_next.apb2_psc = WDATA[CFG_APB2 +: 3];
          st_next.adc_psc = WDATA[CFG_ADC +: 3];
          st_next.pll_src = WDATA[CFG_PLLSRC];
          st_next.usb_psc = WDATA[CFG_USB +: 2];
          st_next.i2s_sel = WDATA[CFG_I2S +: 2];
        end
        RCU_INT_OFS:
        begin
          st_next.ie = WDATA[INT_IE +: 5];
          flag_clr = WDATA[INT_CLR +: 5];
          ckm_clr = WDATA[INT_CKMC];
        end
        RCU_BDC_OFS:
        begin
          st_next.rtc_src = rcu_rtc_t'(WDATA[BDC_RTC_SOURCE_SELECT +: 2]);
          st_next.rtc_en = WDATA[BDC_RTCEN];
          st_next.bkp_bit = WDATA[BDC_BACKUP_DOMAIN_RESET_BIT];
        end
        default:
        begin
          st_next.rdata = st_reg.rdata;
        end
      endcase
    end

    // low-power entry stops the crystal and every PLL
    if (RST_SRC.deepsleep_entry | RST_SRC.standby_entry)
    begin
      st_next.pll_en = 3'h0;
      st_next.hx_en = 1'b0;
    end
    if (RST_SRC.deepsleep_wake && st_reg.sel != RCU_SRC_INTERNAL_8M_OSC)
    begin
      st_next.system_clock_switch = RCU_SRC_INTERNAL_8M_OSC;
      st_next.sel = RCU_SRC_INTERNAL_8M_OSC;
    end

    // crystal monitor failure
    hx_fail = st_reg.ckm_en & st_reg.hx_en & OSC_RDY.high_speed_crystal_fail;
    if (hx_fail)
    begin
      st_next.hx_en = 1'b0;
      if (st_reg.pll_src)
      begin
        st_next.pll_en = 3'h0;
      end
      if (st_reg.sel == RCU_SRC_HIGH_SPEED_CRYSTAL || (st_reg.sel == RCU_SRC_PLL && st_reg.pll_src))
      begin
        st_next.system_clock_switch = RCU_SRC_INTERNAL_8M_OSC;
        st_next.sel = RCU_SRC_INTERNAL_8M_OSC;
      end
      if (st_reg.rtc_src == RCU_RTC_HXDIV)
      begin
        st_next.rtc_src = RCU_RTC_NONE;
      end
    end
    // a set in the clearing cycle wins
    st_next.ckm_flag = (st_reg.ckm_flag & !ckm_clr) | hx_fail;
    st_next.flag = (st_reg.flag & ~flag_clr) | stb_set;

    // a software switch moves the selector only once the target reports stable; wake and crystal failure force 8M at once
    if (st_next.sel != st_next.system_clock_switch)
    begin
      unique case (st_next.system_clock_switch)
        RCU_SRC_INTERNAL_8M_OSC: if (st_reg.stb[0]) st_next.sel = st_next.system_clock_switch;
        RCU_SRC_HIGH_SPEED_CRYSTAL: if (st_reg.stb[1]) st_next.sel = st_next.system_clock_switch;
        RCU_SRC_PLL: if (st_reg.stb[2]) st_next.sel = st_next.system_clock_switch;
        default: st_next.sel = RCU_SRC_INTERNAL_8M_OSC;
      endcase
    end

    // register reads
    st_next.rdata = 32'h0000_0000;
    if (RE)
    begin
      unique case (ADDR)
        RCU_CTL_OFS:
        begin
          st_next.rdata[CTL_INTERNAL_8M_OSC_EN] = st_reg.internal_8m_osc_en;
          st_next.rdata[CTL_INTERNAL_8M_OSC_STB] = st_reg.stb[0];
          st_next.rdata[CTL_INTERNAL_40K_OSC_EN] = st_reg.internal_40k_osc_en;
          st_next.rdata[CTL_INTERNAL_40K_OSC_STB] = st_reg.internal_40k_osc_stb;
          st_next.rdata[CTL_HX_EN] = st_reg.hx_en;
          st_next.rdata[CTL_HX_STB] = st_reg.stb[1];
          st_next.rdata[CTL_HX_BPS] = st_reg.hx_bps;
          st_next.rdata[CTL_CKM_EN] = st_reg.ckm_en;
          st_next.rdata[CTL_PLL_EN +: 6] = {st_reg.stb[4], st_reg.pll_en[2], st_reg.stb[3],
            st_reg.pll_en[1], st_reg.stb[2], st_reg.pll_en[0]};
        end
        RCU_CFG_OFS:
        begin
          st_next.rdata[CFG_SCS +: 2] = st_reg.system_clock_switch;
          st_next.rdata[CFG_SEL +: 2] = st_reg.sel;
          st_next.rdata[CFG_AHB +: 3] = st_reg.ahb_psc;
          st_next.rdata[CFG_APB1 +: 3] = st_reg.apb1_psc;
          st_next.rdata[CFG_APB2 +: 3] = st_reg.apb2_psc;
          st_next.rdata[CFG_ADC +: 3] = st_reg.adc_psc;
          st_next.rdata[CFG_PLLSRC] = st_reg.pll_src;
          st_next.rdata[CFG_USB +: 2] = st_reg.usb_psc;
          st_next.rdata[CFG_I2S +: 2] = st_reg.i2s_sel;
        end
        RCU_INT_OFS:
        begin
          st_next.rdata[INT_FLAG +: 5] = st_reg.flag;
          st_next.rdata[INT_CKMF] = st_reg.ckm_flag;
          st_next.rdata[INT_IE +: 5] = st_reg.ie;
        end
        RCU_BDC_OFS:
        begin
          st_next.rdata[BDC_RTC_SOURCE_SELECT +: 2] = st_reg.rtc_src;
          st_next.rdata[BDC_RTCEN] = st_reg.rtc_en;
          st_next.rdata[BDC_BACKUP_DOMAIN_RESET_BIT] = st_reg.bkp_bit;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // source ticks; the crystal stays withheld until its flag is set
    hx_tick = (st_reg.hx_bps ? OSC_TICK.oscin : OSC_TICK.high_speed_crystal_osc) & st_reg.stb[1];
    pll_t = OSC_TICK.pll & st_reg.stb[2];
    // ticks are muxed on a registered selector, so no runt pulse can appear
    unique case (st_reg.sel)
      RCU_SRC_INTERNAL_8M_OSC: sys_t = OSC_TICK.internal_8m_osc & st_reg.stb[0];
      RCU_SRC_HIGH_SPEED_CRYSTAL: sys_t = hx_tick;
      RCU_SRC_PLL: sys_t = pll_t;
      default: sys_t = OSC_TICK.internal_8m_osc;
    endcase

    // bus prescalers, each a power of two
    ahb_mask = 7'((8'h01 << st_reg.ahb_psc) - 8'h01);
    apb1_mask = 7'((8'h01 << st_reg.apb1_psc) - 8'h01);
    apb2_mask = 7'((8'h01 << st_reg.apb2_psc) - 8'h01);
    ahb_t = sys_t && (st_reg.ahb_cnt == ahb_mask);
    apb1_t = ahb_t && (st_reg.apb1_cnt == apb1_mask);
    apb2_t = ahb_t && (st_reg.apb2_cnt == apb2_mask);
    if (sys_t)
    begin
      st_next.ahb_cnt = ahb_t ? 7'h00 : st_reg.ahb_cnt + 7'h01;
    end
    if (ahb_t)
    begin
      st_next.apb1_cnt = apb1_t ? 7'h00 : st_reg.apb1_cnt + 7'h01;
      st_next.apb2_cnt = apb2_t ? 7'h00 : st_reg.apb2_cnt + 7'h01;
      st_next.tick_cnt = st_reg.tick_cnt + 3'h1;
    end
    adc_top = adc_top_of(st_reg.adc_psc);
    if (apb2_t)
    begin
      st_next.adc_cnt = (st_reg.adc_cnt == adc_top) ? 4'h0 : st_reg.adc_cnt + 4'h1;
    end
    if (pll_t)
    begin
      st_next.usb_cnt = (st_reg.usb_cnt == st_reg.usb_psc) ? 2'h0 : st_reg.usb_cnt + 2'h1;
    end
    if (hx_tick)
    begin
      st_next.rtc_cnt = st_reg.rtc_cnt + 7'h01;
    end

    // derived clock ticks, registered for clean outputs
    st_next.clk_o.sys = sys_t;
    st_next.clk_o.ahb = ahb_t;
    st_next.clk_o.apb1 = apb1_t;
    st_next.clk_o.apb2 = apb2_t;
    // half the prescaler count gives twice the bus rate; with an undivided bus the timer tick equals the bus tick
    st_next.clk_o.tmr1 = (st_reg.apb1_psc == 3'h0) ? apb1_t
      : ahb_t && ((st_reg.apb1_cnt & (apb1_mask >> 1)) == (apb1_mask >> 1));
    st_next.clk_o.tmr2 = (st_reg.apb2_psc == 3'h0) ? apb2_t
      : ahb_t && ((st_reg.apb2_cnt & (apb2_mask >> 1)) == (apb2_mask >> 1));
    st_next.clk_o.system_tick_timer_ext = ahb_t && (st_reg.tick_cnt == RCU_SYSTEM_TICK_TIMER_TOP);
    st_next.clk_o.adc = apb2_t && (st_reg.adc_cnt == adc_top);
    st_next.clk_o.usb = pll_t && (st_reg.usb_cnt == st_reg.usb_psc);
    for (int i = 0; i < 2; i++)
    begin
      st_next.clk_o.i2s[i] = st_reg.i2s_sel[i] ? (OSC_TICK.pll2x2 & st_reg.stb[4]) : sys_t;
    end
    unique case (st_reg.rtc_src)
      RCU_RTC_NONE: st_next.clk_o.rtc = 1'b0;
      RCU_RTC_LOW_SPEED_CRYSTAL: st_next.clk_o.rtc = st_reg.rtc_en & OSC_TICK.low_speed_crystal;
      RCU_RTC_INTERNAL_40K_OSC: st_next.clk_o.rtc = st_reg.rtc_en & OSC_TICK.internal_40k_osc;
      RCU_RTC_HXDIV: st_next.clk_o.rtc = st_reg.rtc_en & hx_tick
        & (st_reg.rtc_cnt == RCU_RTC_HX_DIV_TOP);
    endcase
    st_next.clk_o.fwdg = OSC_TICK.internal_40k_osc;
    st_next.clk_o.flash = OSC_TICK.internal_8m_osc;

    // power and system reset return control state; backup fields are spared
    if (!st_reg.pwr_n || !st_reg.sys_n)
    begin
      st_next.internal_8m_osc_en = RCU_INTERNAL_8M_OSC_EN_RST;
      st_next.hx_en = 1'b0;
      st_next.hx_bps = 1'b0;
      st_next.ckm_en = 1'b0;
      st_next.pll_en = 3'h0;
      st_next.system_clock_switch = RCU_SRC_INTERNAL_8M_OSC;
      st_next.sel = RCU_SRC_INTERNAL_8M_OSC;
      st_next.ahb_psc = 3'h0;
      st_next.apb1_psc = 3'h0;
      st_next.apb2_psc = 3'h0;
      st_next.adc_psc = 3'h0;
      st_next.pll_src = 1'b0;
      st_next.usb_psc = 2'h0;
      st_next.i2s_sel = 2'h0;
      st_next.ie = 5'h00;
      st_next.flag = 5'h00;
      st_next.ckm_flag = 1'b0;
    end
    if (!st_reg.pwr_n)
    begin
      st_next.internal_40k_osc_en = 1'b0;
    end
    if (!st_reg.bkp_n)
    begin
      st_next.rtc_src = RCU_RTC_NONE;
      st_next.rtc_en = 1'b0;
    end
  end

  // state register; asynchronous reset loads all zeros, power reset then follows
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign RDATA = st_reg.rdata;
  assign POWER_RESET_N = st_reg.pwr_n;
  assign SYSTEM_RESET_N = st_reg.sys_n;
  assign BACKUP_RESET_N = st_reg.bkp_n;
  assign RESET_VECTOR = RCU_RESET_VECTOR;
  assign STABLE_IRQ = |(st_reg.flag & st_reg.ie);
  assign NMI = st_reg.ckm_flag;
  assign CLK_TICK = st_reg.clk_o;
  assign OSC_EN.internal_8m_osc = st_reg.internal_8m_osc_en | st_reg.ckm_en | (st_reg.sel == RCU_SRC_INTERNAL_8M_OSC);
  assign OSC_EN.high_speed_crystal_amp = st_reg.hx_en & !st_reg.hx_bps;
  assign OSC_EN.internal_40k_osc = st_reg.internal_40k_osc_en | RST_SRC.fwdg_started;
  assign OSC_EN.pll = st_reg.pll_en;
endmodule : rcu_top

// >>> logic/rcu_pkg.sv
/*
  rcu_pkg: constants, field positions and carrier types of the reset and clock unit.
  Assumes one 20 MHz core clock; every oscillator and PLL output reaches the unit as a
  one-cycle tick that is synchronous to that clock.
*/
package rcu_pkg;
  // register offsets
  localparam logic [7:0] RCU_CTL_OFS = 8'h00;
  localparam logic [7:0] RCU_CFG_OFS = 8'h04;
  localparam logic [7:0] RCU_INT_OFS = 8'h08;
  localparam logic [7:0] RCU_BDC_OFS = 8'h0C;
  // control register fields
  localparam int CTL_INTERNAL_8M_OSC_EN = 0;
  localparam int CTL_INTERNAL_8M_OSC_STB = 1;
  localparam int CTL_INTERNAL_40K_OSC_EN = 4;
  localparam int CTL_INTERNAL_40K_OSC_STB = 5;
  localparam int CTL_HX_EN = 16;
  localparam int CTL_HX_STB = 17;
  localparam int CTL_HX_BPS = 18;
  localparam int CTL_CKM_EN = 19;
  localparam int CTL_PLL_EN = 24;
  localparam int CTL_PLL_STB = 25;
  // configuration register fields
  localparam int CFG_SCS = 0;
  localparam int CFG_SEL = 2;
  localparam int CFG_AHB = 4;
  localparam int CFG_APB1 = 8;
  localparam int CFG_APB2 = 11;
  localparam int CFG_ADC = 14;
  localparam int CFG_PLLSRC = 17;
  localparam int CFG_USB = 18;
  localparam int CFG_I2S = 20;
  // interrupt register fields
  localparam int INT_FLAG = 0;
  localparam int INT_CKMF = 7;
  localparam int INT_IE = 8;
  localparam int INT_CLR = 16;
  localparam int INT_CKMC = 23;
  // backup domain control fields
  localparam int BDC_RTC_SOURCE_SELECT = 8;
  localparam int BDC_RTCEN = 15;
  localparam int BDC_BACKUP_DOMAIN_RESET_BIT = 16;
  // reset values and timing
  localparam logic RCU_INTERNAL_8M_OSC_EN_RST = 1'b1;
  localparam logic [31:0] RCU_RESET_VECTOR = 32'h0000_0000;
  localparam int RCU_CLK_MHZ = 20;
  localparam int RCU_STRETCH_US = 20;
  localparam logic [8:0] RCU_STRETCH_CYC = 9'(RCU_STRETCH_US * RCU_CLK_MHZ);
  localparam logic [6:0] RCU_RTC_HX_DIV_TOP = 7'h7F;
  localparam logic [2:0] RCU_SYSTEM_TICK_TIMER_TOP = 3'h7;

  typedef enum logic [1:0] {
    RCU_SRC_INTERNAL_8M_OSC = 2'h0,
    RCU_SRC_HIGH_SPEED_CRYSTAL = 2'h1,
    RCU_SRC_PLL = 2'h2
  } rcu_src_t;

  typedef enum logic [1:0] {
    RCU_RTC_NONE = 2'h0,
    RCU_RTC_LOW_SPEED_CRYSTAL = 2'h1,
    RCU_RTC_INTERNAL_40K_OSC = 2'h2,
    RCU_RTC_HXDIV = 2'h3
  } rcu_rtc_t;

  // reset sources and option levels
  typedef struct packed {
    logic por_det;
    logic standby_exit;
    logic ldo_ready;
    logic external_reset_pin_n;
    logic window_watchdog_reset_n;
    logic free_watchdog_reset_n;
    logic software_reset_request;
    logic standby_entry;
    logic deepsleep_entry;
    logic standby_no_reset_option;
    logic deepsleep_no_reset_option;
    logic deepsleep_wake;
    logic bkp_power_on;
    logic fwdg_started;
  } rcu_rst_src_t;

  // oscillator and PLL ticks
  typedef struct packed {
    logic internal_8m_osc;
    logic high_speed_crystal_osc;
    logic oscin;
    logic internal_40k_osc;
    logic low_speed_crystal;
    logic pll;
    logic pll1;
    logic pll2x2;
  } rcu_osc_t;

  // ready levels reported by the analog side
  typedef struct packed {
    logic internal_8m_osc;
    logic high_speed_crystal;
    logic internal_40k_osc;
    logic pll;
    logic pll1;
    logic pll2;
    logic high_speed_crystal_fail;
  } rcu_rdy_t;

  typedef struct packed {
    logic internal_8m_osc;
    logic high_speed_crystal_amp;
    logic internal_40k_osc;
    logic [2:0] pll;
  } rcu_oscen_t;

  // derived clock ticks
  typedef struct packed {
    logic sys;
    logic ahb;
    logic apb1;
    logic apb2;
    logic tmr1;
    logic tmr2;
    logic system_tick_timer_ext;
    logic adc;
    logic usb;
    logic [1:0] i2s;
    logic rtc;
    logic fwdg;
    logic flash;
  } rcu_clk_t;
endpackage : rcu_pkg

// >>> tb/rcu_props.sv
/*
  rcu_props: port checks of rcu_top.
  Assumes it is bound to rcu_top and that everything runs on CLK.
*/
`timescale 1ns/1ps
module rcu_props
  import rcu_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire rcu_rst_src_t RST_SRC,
  input wire rcu_osc_t OSC_TICK,
  input wire rcu_rdy_t OSC_RDY,
  input wire rcu_oscen_t OSC_EN,
  input wire rcu_clk_t CLK_TICK,
  input wire logic POWER_RESET_N,
  input wire logic SYSTEM_RESET_N,
  input wire logic BACKUP_RESET_N,
  input wire logic [31:0] RESET_VECTOR,
  input wire logic NMI
);
  localparam int MIN_LOW = 399;
  logic [9:0] low_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // low time of system reset; saturates so long holds stay legal
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      low_reg <= '0;
    else if (SYSTEM_RESET_N)
      low_reg <= '0;
    else if (low_reg != 10'h3FF)
      low_reg <= low_reg + 10'h001;
  end
  property p_vec;
    RESET_VECTOR == 32'h0000_0000;
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector moved");
  property p_por;
    (RST_SRC.por_det || RST_SRC.standby_exit) |=> !POWER_RESET_N;
  endproperty
  a_por: assert property (p_por) else $error("power reset missed");
  property p_ldo;
    !RST_SRC.ldo_ready |=> !POWER_RESET_N;
  endproperty
  a_ldo: assert property (p_ldo) else $error("power reset before supply");
  property p_sys;
    (!RST_SRC.external_reset_pin_n || !RST_SRC.window_watchdog_reset_n
      || !RST_SRC.free_watchdog_reset_n || RST_SRC.software_reset_request)
      |-> ##[1:2] !SYSTEM_RESET_N;
  endproperty
  a_sys: assert property (p_sys) else $error("system reset missed");
  property p_stretch;
    $rose(SYSTEM_RESET_N) |-> low_reg >= MIN_LOW;
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset pulse short");
  property p_bkp;
    RST_SRC.bkp_power_on |-> ##[1:2] !BACKUP_RESET_N;
  endproperty
  a_bkp: assert property (p_bkp) else $error("backup reset missed");
  property p_nmi;
    $rose(NMI) |-> $past(OSC_RDY.high_speed_crystal_fail) || $past(OSC_RDY.high_speed_crystal_fail, 2);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without failure");
  property p_flash;
    CLK_TICK.flash |-> $past(OSC_TICK.internal_8m_osc);
  endproperty
  a_flash: assert property (p_flash) else $error("flash tick source");
  property p_fwdg;
    CLK_TICK.fwdg |-> $past(OSC_TICK.internal_40k_osc);
  endproperty
  a_fwdg: assert property (p_fwdg) else $error("watchdog tick source");
  property p_forced;
    RST_SRC.fwdg_started [*2] |-> OSC_EN.internal_40k_osc;
  endproperty
  a_forced: assert property (p_forced) else $error("40k not forced");
  property p_sleep;
    RST_SRC.deepsleep_entry |-> ##[1:2] OSC_EN.pll == 3'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("pll left on");
endmodule : rcu_props

bind rcu_top rcu_props u_props (
  .CLK(CLK), .RSTN(RSTN), .RST_SRC(RST_SRC), .OSC_TICK(OSC_TICK), .OSC_RDY(OSC_RDY),
  .OSC_EN(OSC_EN), .CLK_TICK(CLK_TICK), .POWER_RESET_N(POWER_RESET_N),
  .SYSTEM_RESET_N(SYSTEM_RESET_N), .BACKUP_RESET_N(BACKUP_RESET_N),
  .RESET_VECTOR(RESET_VECTOR), .NMI(NMI)
);

// >>> tb/rcu_osc_model.sv
/*
  rcu_osc_model: oscillators and PLLs as tick sources with start-up delay.
  Assumes the enables of rcu_top and one shared core clock.
*/
`timescale 1ns/1ps
module rcu_osc_model
  import rcu_pkg::*;
#(
  parameter int DLY = 40
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire rcu_oscen_t en,
  input wire logic fail,
  output rcu_osc_t tick,
  output rcu_rdy_t rdy
);
  logic [5:0] on;
  logic [5:0] rd;
  logic [3:0] ph;
  logic hx;
  logic [7:0] cnt [6];
  assign on = {en.internal_8m_osc, en.high_speed_crystal_amp, en.internal_40k_osc, en.pll[0], en.pll[1], en.pll[2]};
  // ticks stand still while a source is off
  assign hx = on[4] & (ph[1:0] == 2'h0);
  assign tick = {on[5] & ph[0], hx, hx, on[3] & (ph[2:0] == 3'h0), ph == 4'h0,
                 on[2], on[1] & ph[0], on[0]};
  // ready only after a start-up delay, so withholding is visible
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      rd[i] = on[i] && cnt[i] == 8'(DLY);
  end
  assign rdy = {rd, fail};
  // start-up counters
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph <= '0;
      for (int i = 0; i < 6; i++)
        cnt[i] <= '0;
    end
    else
    begin
      ph <= ph + 4'h1;
      for (int i = 0; i < 6; i++)
        cnt[i] <= !on[i] ? 8'h00 : (cnt[i] == 8'(DLY) ? cnt[i] : cnt[i] + 8'h01);
    end
  end
endmodule : rcu_osc_model

// >>> tb/rcu_top_tb.sv
/*
  rcu_top_tb: directed scenarios for the reset and clock unit.
  Assumes rcu_props bound to rcu_top and rcu_osc_model as the analog side.
*/
`timescale 1ns/1ps
module rcu_top_tb
  import rcu_pkg::*;
;
  // all sources quiet, entry options set so entries do not reset
  localparam rcu_rst_src_t IDLE = 14'h0F18;
  localparam logic [13:0] PULSE [8] = '{14'h0400, 14'h0200, 14'h0100, 14'h0080,
                                        14'h0050, 14'h0028, 14'h2000, 14'h1000};
  logic clk, rstn, we, re, fail, por_n, sys_n, bkp_n, irq, nmi;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, vec, d;
  rcu_rst_src_t src;
  rcu_osc_t tick;
  rcu_rdy_t rdy;
  rcu_oscen_t en;
  rcu_clk_t ck;
  int n_fail = 0;
  int n_compared = 0;
  rcu_top u_dut (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
    .RDATA(rdata), .RST_SRC(src), .OSC_TICK(tick), .OSC_RDY(rdy), .OSC_EN(en),
    .CLK_TICK(ck), .POWER_RESET_N(por_n), .SYSTEM_RESET_N(sys_n),
    .BACKUP_RESET_N(bkp_n), .RESET_VECTOR(vec), .STABLE_IRQ(irq), .NMI(nmi)
  );
  rcu_osc_model u_osc (.clk(clk), .rstn(rstn), .en(en), .fail(fail), .tick(tick), .rdy(rdy));
  // 20 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic wait_hi(ref logic s, output int n);
    for (n = 0; s !== 1'b1; n++)
    begin
      if (n == 2000)
      begin
        n_fail++;
        finish_test();
      end
      @(posedge clk);
      #1;
    end
  endtask : wait_hi
  task automatic t_power();
    int n;
    repeat (5) @(posedge clk);
    #1 chk(por_n, 1'b0);
    @(posedge clk);
    src.ldo_ready <= 1'b1;
    wait_hi(sys_n, n);
    chk(n >= RCU_STRETCH_CYC, 1'b1);
    chk(por_n, 1'b1);
    rd(RCU_CTL_OFS, d);
    chk(d[1:0], 2'h3);
    rd(RCU_CFG_OFS, d);
    chk(d[3:2], 2'h0);
  endtask : t_power
  task automatic t_sources();
    int n;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      src <= IDLE ^ PULSE[i];
      @(posedge clk);
      src <= IDLE;
      @(posedge clk);
      #1 chk(sys_n, 1'b0);
      wait_hi(sys_n, n);
      chk(n >= RCU_STRETCH_CYC - 3, 1'b1);
    end
  endtask : t_sources
  task automatic t_hx();
    int n, na, ne, nf, nt, np, nc;
    wr(RCU_CTL_OFS, 32'h0001_0001);
    wr(RCU_INT_OFS, 32'h0000_0200);
    wr(RCU_CFG_OFS, 32'h0000_0101);
    rd(RCU_CFG_OFS, d);
    chk(d[3:2], 2'h0);
    chk(irq, 1'b0);
    wait_hi(irq, n);
    rd(RCU_CFG_OFS, d);
    chk(d[3:2], 2'h1);
    {na, ne, nf, nt, np, nc} = '0;
    // every period divides the window, so counts are exact
    for (int c = 0; c < 800; c++)
    begin
      @(posedge clk);
      #1;
      na += ck.ahb;
      ne += ck.system_tick_timer_ext;
      nf += ck.flash;
      nt += ck.tmr1;
      np += ck.apb1;
      nc += ck.adc;
    end
    chk(na, 200);
    chk(ne, 25);
    chk(nc, 100);
    chk(np, 100);
    chk(nt, 200);
    chk(nf, 400);
    wr(RCU_INT_OFS, 32'h0002_0200);
    @(posedge clk);
    #1 chk(irq, 1'b0);
  endtask : t_hx
  task automatic t_fail();
    wr(RCU_CTL_OFS, 32'h0009_0001);
    @(posedge clk);
    fail <= 1'b1;
    repeat (3) @(posedge clk);
    fail <= 1'b0;
    #1 chk(nmi, 1'b1);
    rd(RCU_CFG_OFS, d);
    chk(d[3:2], 2'h0);
    rd(RCU_CTL_OFS, d);
    chk(d[16], 1'b0);
    rd(RCU_INT_OFS, d);
    chk(d[7], 1'b1);
    wr(RCU_INT_OFS, 32'h0080_0000);
    repeat (2) @(posedge clk);
    #1 chk(nmi, 1'b0);
  endtask : t_fail
  task automatic t_sleep();
    int na, nb, nc;
    wr(RCU_CTL_OFS, 32'h1500_0001);
    repeat (60) @(posedge clk);
    rd(RCU_CTL_OFS, d);
    chk(d[29:24], 6'h3F);
    wr(RCU_INT_OFS, 32'h0000_1000);
    #1 chk(irq, 1'b1);
    wr(RCU_INT_OFS, 32'h0000_0000);
    #1 chk(irq, 1'b0);
    // run on the PLL, usb divides by three, first audio clock on the third PLL
    wr(RCU_CFG_OFS, 32'h0018_0002);
    repeat (4) @(posedge clk);
    {na, nb, nc} = '0;
    for (int c = 0; c < 60; c++)
    begin
      @(posedge clk);
      #1;
      na += ck.usb;
      nb += ck.i2s[0];
      nc += ck.i2s[1];
    end
    chk(na, 20);
    chk(nb, 60);
    chk(nc, 60);
    // entry and wake together: PLLs stop, selection falls back to 8M
    @(posedge clk);
    src.deepsleep_entry <= 1'b1;
    src.deepsleep_wake <= 1'b1;
    src.fwdg_started <= 1'b1;
    @(posedge clk);
    src.deepsleep_entry <= 1'b0;
    src.deepsleep_wake <= 1'b0;
    rd(RCU_CTL_OFS, d);
    chk(d[29:24], 6'h00);
    rd(RCU_CFG_OFS, d);
    chk(d[3:0], 4'h0);
    chk(sys_n, 1'b1);
    chk(en.internal_40k_osc, 1'b1);
  endtask : t_sleep
  task automatic t_misc();
    int nr, nw;
    wr(RCU_BDC_OFS, 32'h0001_0000);
    @(posedge clk);
    #1 chk(bkp_n, 1'b0);
    wr(RCU_BDC_OFS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk(bkp_n, 1'b1);
    rd(8'h10, d);
    chk(d, 32'h0000_0000);
    chk(vec, 32'h0000_0000);
    // backup-domain power-on
    @(posedge clk);
    src.bkp_power_on <= 1'b1;
    @(posedge clk);
    src.bkp_power_on <= 1'b0;
    #1 chk(bkp_n, 1'b0);
    // rtc on the 40k source, which the started watchdog keeps running
    wr(RCU_BDC_OFS, 32'h0000_8200);
    {nr, nw} = '0;
    for (int c = 0; c < 64; c++)
    begin
      @(posedge clk);
      #1;
      nr += ck.rtc;
      nw += ck.fwdg;
    end
    chk(nr, 8);
    chk(nw, 8);
  endtask : t_misc
  // main sequence; supply starts not ready
  initial
  begin
    rstn = 1'b0;
    src = IDLE ^ 14'h0800;
    {addr, wdata, we, re, fail} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_power();
    t_sources();
    t_hx();
    t_fail();
    t_sleep();
    t_misc();
    finish_test();
  end
endmodule : rcu_top_tb
